// ==== wbm_area.v ====
// classifies a word address into its data area.
// assumes 15-bit addresses so that sums running past memory stay visible.
`timescale 1ns/1ps
`include "wbm_map.vh"

module wbm_area (
    input wire [14:0] addr,
    output reg [1:0] area
);
    always @* begin
        if (addr < `WBM_DM_WORDS)
            area = 2'h0;
        else if (addr < `WBM_OTHER_FIRST)
            area = 2'h1;
        else if (addr < `WBM_MEM_WORDS)
            area = 2'h2;
        else
            area = `WBM_AREA_NONE;
    end
endmodule

// ==== wbm_bcd.v ====
// four-digit bcd checker and bcd to binary converter.
// assumes a 16-bit word holding four packed bcd digits.
`timescale 1ns/1ps
`include "wbm_map.vh"

module wbm_bcd (
    input wire [15:0] bcd,
    output wire ok,
    output wire [13:0] bin
);
    wire [13:0] d3 = {10'h000, bcd[15:12]};
    wire [13:0] d2 = {10'h000, bcd[11:8]};
    wire [13:0] d1 = {10'h000, bcd[7:4]};
    wire [13:0] d0 = {10'h000, bcd[3:0]};

    assign ok = (bcd[15:12] <= 4'h9) && (bcd[11:8] <= 4'h9) &&
                (bcd[7:4] <= 4'h9) && (bcd[3:0] <= 4'h9);
    // result fits 14 bits only for legal digits; callers gate on ok
    assign bin = d3 * 14'd1000 + d2 * 14'd100 + d1 * 14'd10 + d0;
endmodule

// ==== wbm_map.vh ====
// constants of the word block move unit: register offsets, field positions,
// reset values, opcodes and the word-memory area map.
// assumes a 32-bit APB slave with byte addresses in paddr[7:0].
`ifndef WBM_MAP_VH
`define WBM_MAP_VH

// ============================================================
// register offsets
`define WBM_REG_CTRL 8'h00
`define WBM_REG_MODE 8'h04
`define WBM_REG_OPA 8'h08
`define WBM_REG_OPB 8'h0C
`define WBM_REG_OPC 8'h10
`define WBM_REG_STATUS 8'h14
`define WBM_REG_MEM_ADDR 8'h18
`define WBM_REG_MEM_DATA 8'h1C

// ============================================================
// field positions
`define WBM_CTRL_COND 0
`define WBM_CTRL_EDGE 1
`define WBM_CTRL_OP_LSB 4
`define WBM_CTRL_OP_MSB 5
`define WBM_MODE_A_IMM 0
`define WBM_MODE_A_IND 1
`define WBM_MODE_B_IND 2
`define WBM_MODE_C_IMM 3
`define WBM_MODE_C_IND 4
`define WBM_STAT_BUSY 0
`define WBM_STAT_ERR 1
`define WBM_STAT_ZERO 2

// ============================================================
// reset values
`define WBM_CTRL_RST 6'h00
`define WBM_MODE_RST 5'h00
`define WBM_OPR_RST 16'h0000

// ============================================================
// operations
`define WBM_OP_COPY 2'h0
`define WBM_OP_FILL 2'h1
`define WBM_OP_SWAP 2'h2
`define WBM_OP_DIST 2'h3

// ============================================================
// word-memory area map (word addresses)
`define WBM_MEM_WORDS 15'h4000
`define WBM_DM_WORDS 15'h2000
`define WBM_TC_FIRST 15'h2000
`define WBM_OTHER_FIRST 15'h2400
`define WBM_PROT_FIRST 15'h1800
`define WBM_PROT_LAST 15'h19FF
`define WBM_AREA_NONE 2'h3
`define WBM_STACK_DIGIT 4'h9

`endif

// ==== wbm_move_unit.v ====
// word block move unit: copy, fill, swap and distribute on word memory.
// assumes an APB master on the same clock and a one-cycle scan_pulse from
// the scan sequencer of the same clock domain.
//
// How it works
// - act only on scans with condition on
// - copy words offset zero through count inclusive
// - copy errors: count not bcd, range crosses area
// - fill writes source from start through end
// - fill errors: areas differ or start above end
// - fill may overwrite timer and counter values
// - swap exchanges both operand words
// - bad indirect pointer raises error
// - top control digit 0-8 selects offset mode
// - offset mode writes source at base plus offset
// - top digit 9 selects stack, length 000-999
// - stack writes base+1+pointer then increments pointer
// - edge mode limits push to one per rise
// - offset or stack length not bcd errors
// - pointer plus one over length errors
// - zero flag follows distribute source value
`timescale 1ns/1ps
`include "wbm_map.vh"

module wbm_move_unit (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire scan_pulse,
    output wire busy,
    output reg done,
    output reg error_flag,
    output reg zero_flag
);
    localparam MEM_WORDS = 16384;
    localparam S_IDLE = 4'h0;
    localparam S_PTR = 4'h1;
    localparam S_FETCH = 4'h2;
    localparam S_CHECK = 4'h3;
    localparam S_COPY = 4'h4;
    localparam S_FILL = 4'h5;
    localparam S_SWAP1 = 4'h6;
    localparam S_SWAP2 = 4'h7;
    localparam S_DIST = 4'h8;
    localparam S_PUSH = 4'h9;

    // ============================================================
    // storage
    reg [15:0] mem [0:MEM_WORDS-1];
    reg [5:0] ctrl_q;
    reg [4:0] mode_q;
    reg [15:0] opr_q [0:2];
    reg [13:0] mem_addr_q;
    reg [3:0] state_q;
    reg [1:0] idx_q;
    reg [13:0] addr_q [0:2];
    reg [15:0] val_q [0:2];
    reg [14:0] cur_q;
    reg [14:0] dst_q;
    reg [13:0] cnt_q;
    reg [15:0] ptr_q;
    reg stack_q;
    reg prev_cond_q;
    reg ok_q;

    wire [1:0] op = ctrl_q[`WBM_CTRL_OP_MSB:`WBM_CTRL_OP_LSB];
    assign busy = (state_q != S_IDLE);

    function prot_hit;
        input [14:0] lo;
        input [14:0] hi;
        begin
            prot_hit = (lo <= `WBM_PROT_LAST) && (hi >= `WBM_PROT_FIRST);
        end
    endfunction

    // pointer stays below 999 when legal, so three digits suffice
    function [15:0] bcd_inc;
        input [15:0] v;
        reg [3:0] d0;
        reg [3:0] d1;
        reg [3:0] d2;
        begin
            d0 = v[3:0];
            d1 = v[7:4];
            d2 = v[11:8];
            if (d0 == 4'h9) begin
                d0 = 4'h0;
                if (d1 == 4'h9) begin
                    d1 = 4'h0;
                    d2 = d2 + 4'h1;
                end else begin
                    d1 = d1 + 4'h1;
                end
            end else begin
                d0 = d0 + 4'h1;
            end
            bcd_inc = {4'h0, d2, d1, d0};
        end
    endfunction

    // ============================================================
    // operand resolution helpers
    reg ind_i;
    reg imm_i;
    reg data_i;
    always @* begin
        ind_i = 1'b0;
        imm_i = 1'b0;
        data_i = 1'b0;
        if (idx_q == 2'h0) begin
            ind_i = mode_q[`WBM_MODE_A_IND];
            imm_i = mode_q[`WBM_MODE_A_IMM];
            data_i = 1'b1;
        end else if (idx_q == 2'h1) begin
            ind_i = mode_q[`WBM_MODE_B_IND];
        end else begin
            ind_i = mode_q[`WBM_MODE_C_IND];
            imm_i = mode_q[`WBM_MODE_C_IMM];
            data_i = (op == `WBM_OP_DIST);
        end
    end

    // ============================================================
    // memory read port of the engine
    reg [13:0] raddr;
    always @* begin
        case (state_q)
            S_PTR: raddr = opr_q[idx_q][13:0];
            S_FETCH: raddr = addr_q[idx_q];
            S_COPY: raddr = cur_q[13:0];
            S_SWAP1: raddr = addr_q[2];
            default: raddr = addr_q[1];
        endcase
    end
    wire [15:0] rdata = mem[raddr];

    // ============================================================
    // bcd decoders and area classification
    wire n_ok;
    wire [13:0] n_bin;
    wire c_ok;
    wire [13:0] c_bin;
    wire r_ok;
    wire [13:0] r_bin;
    wire stack_mode = (val_q[2][15:12] == `WBM_STACK_DIGIT);
    wire [15:0] ctl_digits = stack_mode ? {4'h0, val_q[2][11:0]} : val_q[2];

    wbm_bcd u_bcd_n (.bcd(val_q[0]), .ok(n_ok), .bin(n_bin));
    wbm_bcd u_bcd_c (.bcd(ctl_digits), .ok(c_ok), .bin(c_bin));
    wbm_bcd u_bcd_r (.bcd(rdata), .ok(r_ok), .bin(r_bin));

    wire [14:0] base = {1'b0, addr_q[1]};
    wire [14:0] len = (op == `WBM_OP_COPY) ? {1'b0, n_bin} : 15'h0000;
    wire [14:0] end_b = base + len;
    wire [14:0] end_c = {1'b0, addr_q[2]} + len;
    wire [14:0] dest = stack_mode ? base + 15'h0001 + {1'b0, r_bin} :
                                    base + {1'b0, c_bin};
    wire [14:0] chk_addr [0:3];
    wire [1:0] chk_area [0:3];
    assign chk_addr[0] = base;
    assign chk_addr[1] = end_b;
    assign chk_addr[2] = (op == `WBM_OP_DIST) ? dest : {1'b0, addr_q[2]};
    assign chk_addr[3] = end_c;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_area
            wbm_area u_area (.addr(chk_addr[g]), .area(chk_area[g]));
        end
    endgenerate

    reg chk_err;
    always @* begin
        chk_err = 1'b0;
        case (op)
            `WBM_OP_COPY: begin
                chk_err = !n_ok ||
                    (chk_area[0] != chk_area[1]) ||
                    (chk_area[2] != chk_area[3]) ||
                    (chk_area[1] == `WBM_AREA_NONE) ||
                    (chk_area[3] == `WBM_AREA_NONE) ||
                    prot_hit({1'b0, addr_q[2]}, end_c);
            end
            `WBM_OP_FILL: begin
                chk_err = (addr_q[1] > addr_q[2]) ||
                    (chk_area[0] != chk_area[2]) ||
                    prot_hit(base, {1'b0, addr_q[2]});
            end
            `WBM_OP_SWAP: begin
                chk_err = prot_hit(base, base) ||
                    prot_hit({1'b0, addr_q[2]}, {1'b0, addr_q[2]});
            end
            default: begin
                chk_err = !c_ok ||
                    prot_hit(base, base) || prot_hit(dest, dest) ||
                    (!mode_q[`WBM_MODE_C_IMM] &&
                     prot_hit({1'b0, addr_q[2]}, {1'b0, addr_q[2]})) ||
                    (chk_area[2] != chk_area[0]) ||
                    (chk_area[2] == `WBM_AREA_NONE) ||
                    (stack_mode && !r_ok) ||
                    (stack_mode && (r_bin + 14'd1 > c_bin));
            end
        endcase
    end

    // ============================================================
    // engine write port
    reg wr_en;
    reg [13:0] wr_addr;
    reg [15:0] wr_data;
    always @* begin
        wr_en = 1'b1;
        wr_addr = dst_q[13:0];
        wr_data = val_q[0];
        case (state_q)
            S_COPY: wr_data = rdata;
            S_FILL: wr_data = val_q[0];
            S_SWAP1: begin
                wr_addr = addr_q[1];
                wr_data = rdata;
            end
            S_SWAP2: begin
                wr_addr = addr_q[2];
                wr_data = ptr_q;
            end
            S_DIST: wr_data = val_q[0];
            S_PUSH: begin
                wr_addr = addr_q[1];
                wr_data = ptr_q;
            end
            default: wr_en = 1'b0;
        endcase
    end

    // ============================================================
    // apb slave
    wire sel_ctrl = (paddr == `WBM_REG_CTRL);
    wire sel_mode = (paddr == `WBM_REG_MODE);
    wire sel_opa = (paddr == `WBM_REG_OPA);
    wire sel_opb = (paddr == `WBM_REG_OPB);
    wire sel_opc = (paddr == `WBM_REG_OPC);
    wire sel_stat = (paddr == `WBM_REG_STATUS);
    wire sel_maddr = (paddr == `WBM_REG_MEM_ADDR);
    wire sel_mdata = (paddr == `WBM_REG_MEM_DATA);
    wire mapped = sel_ctrl | sel_mode | sel_opa | sel_opb | sel_opc |
                  sel_stat | sel_maddr | sel_mdata;
    // operands and memory are in use while an operation runs: stall them
    wire stall_sel = sel_mode | sel_opa | sel_opb | sel_opc | sel_mdata;
    wire stall = stall_sel && busy;
    assign pready = penable && ok_q && !stall;
    assign pslverr = pready && !mapped;
    wire apb_wr = psel && penable && pready && pwrite && mapped;

    reg [31:0] rd_val;
    always @* begin
        if (sel_ctrl)
            rd_val = {26'h0000000, ctrl_q};
        else if (sel_mode)
            rd_val = {27'h0000000, mode_q};
        else if (sel_opa)
            rd_val = {16'h0000, opr_q[0]};
        else if (sel_opb)
            rd_val = {16'h0000, opr_q[1]};
        else if (sel_opc)
            rd_val = {16'h0000, opr_q[2]};
        else if (sel_stat)
            rd_val = {29'h00000000, zero_flag, error_flag, busy};
        else if (sel_maddr)
            rd_val = {18'h00000, mem_addr_q};
        else if (sel_mdata)
            rd_val = {16'h0000, mem[mem_addr_q]};
        else
            rd_val = 32'h00000000;
    end

    // read data is captured a cycle ahead so prdata comes from a flop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ok_q <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            ok_q <= psel && !stall && !(penable && pready);
            if (psel && !stall)
                prdata <= rd_val;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `WBM_CTRL_RST;
            mode_q <= `WBM_MODE_RST;
            opr_q[0] <= `WBM_OPR_RST;
            opr_q[1] <= `WBM_OPR_RST;
            opr_q[2] <= `WBM_OPR_RST;
            mem_addr_q <= 14'h0000;
        end else if (apb_wr) begin
            if (sel_ctrl)
                ctrl_q <= pwdata[5:0];
            else if (sel_mode)
                mode_q <= pwdata[4:0];
            else if (sel_opa)
                opr_q[0] <= pwdata[15:0];
            else if (sel_opb)
                opr_q[1] <= pwdata[15:0];
            else if (sel_opc)
                opr_q[2] <= pwdata[15:0];
            else if (sel_maddr)
                mem_addr_q <= pwdata[13:0];
        end
    end

    // memory holds no reset; software and the engine never write together
    always @(posedge clk) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        else if (apb_wr && sel_mdata)
            mem[mem_addr_q] <= pwdata[15:0];
    end

    // ============================================================
    // operation sequencer
    wire cond_now = ctrl_q[`WBM_CTRL_COND];
    wire fire = cond_now && (!ctrl_q[`WBM_CTRL_EDGE] || !prev_cond_q);
    wire ptr_bad = !r_ok || ({1'b0, r_bin} >= `WBM_DM_WORDS);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            idx_q <= 2'h0;
            addr_q[0] <= 14'h0000;
            addr_q[1] <= 14'h0000;
            addr_q[2] <= 14'h0000;
            val_q[0] <= 16'h0000;
            val_q[1] <= 16'h0000;
            val_q[2] <= 16'h0000;
            cur_q <= 15'h0000;
            dst_q <= 15'h0000;
            cnt_q <= 14'h0000;
            ptr_q <= 16'h0000;
            stack_q <= 1'b0;
            prev_cond_q <= 1'b0;
            done <= 1'b0;
            error_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (scan_pulse) begin
                        prev_cond_q <= cond_now;
                        if (fire) begin
                            error_flag <= 1'b0;
                            idx_q <= (op == `WBM_OP_SWAP) ? 2'h1 : 2'h0;
                            state_q <= S_PTR;
                        end
                    end
                end
                S_PTR: begin
                    if (data_i && imm_i) begin
                        val_q[idx_q] <= opr_q[idx_q];
                    end
                    if (!imm_i && ind_i && ptr_bad) begin
                        error_flag <= 1'b1;
                        done <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        addr_q[idx_q] <= (ind_i && !imm_i) ? r_bin :
                                         opr_q[idx_q][13:0];
                        if (data_i && !imm_i)
                            state_q <= S_FETCH;
                        else if (idx_q == 2'h2)
                            state_q <= S_CHECK;
                        else
                            idx_q <= idx_q + 2'h1;
                    end
                end
                S_FETCH: begin
                    val_q[idx_q] <= rdata;
                    if (idx_q == 2'h2) begin
                        state_q <= S_CHECK;
                    end else begin
                        idx_q <= idx_q + 2'h1;
                        state_q <= S_PTR;
                    end
                end
                S_CHECK: begin
                    if (op == `WBM_OP_DIST)
                        zero_flag <= (val_q[0] == 16'h0000);
                    cur_q <= base;
                    stack_q <= stack_mode;
                    ptr_q <= (op == `WBM_OP_SWAP) ? rdata : bcd_inc(rdata);
                    if (chk_err) begin
                        error_flag <= 1'b1;
                        done <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (op == `WBM_OP_COPY) begin
                        dst_q <= {1'b0, addr_q[2]};
                        cnt_q <= n_bin;
                        state_q <= S_COPY;
                    end else if (op == `WBM_OP_FILL) begin
                        dst_q <= base;
                        cnt_q <= addr_q[2] - addr_q[1];
                        state_q <= S_FILL;
                    end else if (op == `WBM_OP_SWAP) begin
                        state_q <= S_SWAP1;
                    end else begin
                        dst_q <= dest;
                        state_q <= S_DIST;
                    end
                end
                S_COPY, S_FILL: begin
                    if (cnt_q == 14'h0000) begin
                        done <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cur_q <= cur_q + 15'h0001;
                        dst_q <= dst_q + 15'h0001;
                        cnt_q <= cnt_q - 14'h0001;
                    end
                end
                S_SWAP1: state_q <= S_SWAP2;
                S_DIST: begin
                    if (stack_q) begin
                        state_q <= S_PUSH;
                    end else begin
                        done <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    done <= 1'b1;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== wbm_move_unit_sva.sv ====
// checker of the word block move unit, bound to its top module.
// assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
`include "wbm_map.vh"
module wbm_move_unit_chk (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire scan_pulse,
    input wire busy,
    input wire done,
    input wire error_flag,
    input wire zero_flag
);
    // ==========
    // shadow of the control bits, seen from finished apb writes
    logic cond_q;
    logic edge_q;
    logic prev_q;
    wire ctrl_wr = psel && penable && pready && pwrite &&
        paddr == `WBM_REG_CTRL;
    wire take = scan_pulse && !busy;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_q <= 1'b0;
            edge_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                cond_q <= pwdata[`WBM_CTRL_COND];
                edge_q <= pwdata[`WBM_CTRL_EDGE];
            end
            if (take) begin
                prev_q <= cond_q;
            end
        end
    end

    // ==========
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_take;
        scan_pulse && !busy;
    endsequence
    sequence s_run;
        busy ##[1:1000] done;
    endsequence

    property p_cond_off;
        s_take ##0 !cond_q |=> !busy;
    endproperty
    property p_cond_on;
        s_take ##0 (cond_q && (!edge_q || !prev_q)) |=> s_run;
    endproperty
    property p_edge;
        s_take ##0 (cond_q && edge_q && prev_q) |=> !busy;
    endproperty
    property p_idle;
        !busy && !scan_pulse |=> !busy;
    endproperty
    property p_done_one;
        done |=> !done && !busy;
    endproperty
    property p_flags;
        !busy ##1 !busy |-> $stable(error_flag) && $stable(zero_flag);
    endproperty
    property p_status_ready;
        psel && penable && paddr == `WBM_REG_STATUS |-> pready;
    endproperty
    property p_slverr;
        pslverr |-> pready && psel && penable &&
            (paddr > `WBM_REG_MEM_DATA || paddr[1:0] != 2'h0);
    endproperty

    a_cond_off: assert property (p_cond_off)
        else $error("operation started with condition off");
    a_cond_on: assert property (p_cond_on)
        else $error("operation did not run to done");
    a_edge: assert property (p_edge)
        else $error("edge mode executed twice on one level");
    a_idle: assert property (p_idle)
        else $error("busy rose without a scan");
    a_done_one: assert property (p_done_one)
        else $error("done not a single pulse ending the run");
    a_flags: assert property (p_flags)
        else $error("flags moved while idle");
    a_status_ready: assert property (p_status_ready)
        else $error("status read was stalled");
    a_slverr: assert property (p_slverr)
        else $error("slave error on a mapped access");
endmodule

bind wbm_move_unit wbm_move_unit_chk u_chk (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scan_pulse, .busy,
    .done, .error_flag, .zero_flag);

// ==== wbm_move_unit_tb.sv ====
// testbench of the word block move unit over apb and scans.
// assumes the scan model wbm_scan_seq and the bound checker.
`timescale 1ns/1ps
`include "wbm_map.vh"
`define CHK(n, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("ERROR %s exp %h got %h", n, e, g); \
    end \
end
module wbm_move_unit_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] lag = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr, scan_pulse, busy, done, error_flag, zero_flag;
    int failures = 0;
    int tests_run = 0;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    logic [15:0] v[5];
    logic [15:0] s;
    logic z = 1'b0;

    always #2 clk = ~clk;

    wbm_move_unit dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .scan_pulse, .busy, .done,
        .error_flag, .zero_flag);
    wbm_scan_seq u_seq (.clk, .rst_n, .go, .lag, .busy, .scan_pulse);

    // ==========
    // read data is judged in the access cycle that pready ends
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            `CHK($sformatf("reg %h", paddr), e, prdata)
            `CHK("pslverr", paddr > 8'h1C, pslverr)
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (!pready) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic mw(input logic [31:0] a, input logic [15:0] d);
        apb(1'b1, `WBM_REG_MEM_ADDR, a);
        apb(1'b1, `WBM_REG_MEM_DATA, {16'h0, d});
    endtask
    task automatic mr(input logic [31:0] a, input logic [15:0] d);
        apb(1'b1, `WBM_REG_MEM_ADDR, a);
        rd(`WBM_REG_MEM_DATA, {16'h0, d});
    endtask
    task automatic st(input logic er);
        rd(`WBM_REG_STATUS, {29'h0, z, er, 1'b0});
    endtask
    task automatic op(input logic [5:0] ctl, input logic [4:0] m,
            input logic [15:0] a, input logic [15:0] b,
            input logic [15:0] c, input logic ex);
        apb(1'b1, `WBM_REG_MODE, {27'h0, m});
        apb(1'b1, `WBM_REG_OPA, {16'h0, a});
        apb(1'b1, `WBM_REG_OPB, {16'h0, b});
        apb(1'b1, `WBM_REG_OPC, {16'h0, c});
        apb(1'b1, `WBM_REG_CTRL, {26'h0, ctl});
        @(posedge clk);
        go <= 1'b1;
        lag <= 4'($urandom_range(0, 3));
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 300 && !done; i++) @(negedge clk);
        `CHK("done", ex, done)
        repeat (2) @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========
    // scenarios
    initial begin
        void'($urandom(44385));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        st(1'b0);
        rd(8'h20, 32'h0);
        for (int i = 0; i < 5; i++) begin
            v[i] = 16'($urandom);
            mw('h100 + i, v[i]);
        end
        mw('h204, 16'h5A5A);
        mw('h1FFC, 16'h3C3C);
        op(6'h01, 5'h01, 16'h0003, 16'h0100, 16'h0200, 1'b1);
        for (int i = 0; i < 4; i++) mr('h200 + i, v[i]);
        mr('h204, 16'h5A5A);
        st(1'b0);
        op(6'h01, 5'h01, 16'h00A0, 16'h0100, 16'h0204, 1'b1);
        st(1'b1);
        op(6'h01, 5'h01, 16'h0005, 16'h1FFC, 16'h0204, 1'b1);
        st(1'b1);
        op(6'h01, 5'h01, 16'h0005, 16'h0100, 16'h1FFC, 1'b1);
        st(1'b1);
        mr('h204, 16'h5A5A);
        mr('h1FFC, 16'h3C3C);
        s = 16'($urandom);
        mw('h2004, 16'hA5A5);
        op(6'h11, 5'h01, s, 16'h2000, 16'h2003, 1'b1);
        for (int i = 0; i < 4; i++) mr('h2000 + i, s);
        mr('h2004, 16'hA5A5);
        op(6'h11, 5'h01, ~s, 16'h2003, 16'h2000, 1'b1);
        st(1'b1);
        op(6'h11, 5'h01, ~s, 16'h1FFF, 16'h2000, 1'b1);
        st(1'b1);
        mr('h2000, s);
        mw('h300, v[0]);
        mw('h301, v[1]);
        op(6'h21, 5'h00, 16'h0000, 16'h0300, 16'h0301, 1'b1);
        mr('h300, v[1]);
        mr('h301, v[0]);
        mw('h310, 16'h00AB);
        mw('h311, 16'h0768);
        op(6'h21, 5'h04, 16'h0000, 16'h0310, 16'h0301, 1'b1);
        st(1'b1);
        op(6'h21, 5'h04, 16'h0000, 16'h0311, 16'h0301, 1'b1);
        mr('h300, v[0]);
        s = 16'($urandom) | 16'h0001;
        op(6'h31, 5'h09, s, 16'h0064, 16'h8005, 1'b1);
        mr('h1FA9, s);
        st(1'b0);
        op(6'h31, 5'h09, 16'h0000, 16'h0400, 16'h0003, 1'b1);
        mr('h403, 16'h0000);
        z = 1'b1;
        st(1'b0);
        op(6'h31, 5'h09, s, 16'h0400, 16'h0A00, 1'b1);
        z = 1'b0;
        st(1'b1);
        op(6'h31, 5'h09, s, 16'h0400, 16'h90A0, 1'b1);
        st(1'b1);
        mw('h500, 16'h0009);
        mw('h50B, 16'h7E7E);
        op(6'h31, 5'h09, s, 16'h0500, 16'h9010, 1'b1);
        mr('h50A, s);
        mr('h500, 16'h0010);
        op(6'h31, 5'h09, s, 16'h0500, 16'h9010, 1'b1);
        st(1'b1);
        mr('h500, 16'h0010);
        mr('h50B, 16'h7E7E);
        mw('h500, 16'h0000);
        op(6'h30, 5'h09, s, 16'h0500, 16'h9010, 1'b0);
        op(6'h33, 5'h09, s, 16'h0500, 16'h9010, 1'b1);
        op(6'h33, 5'h09, s, 16'h0500, 16'h9010, 1'b0);
        mr('h500, 16'h0001);
        mr('h501, s);
        op(6'h31, 5'h0A, 16'h0311, 16'h0600, 16'h0002, 1'b1);
        mr('h602, v[0]);
        tally_and_finish();
    end

    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
endmodule

// ==== wbm_scan_seq.sv ====
// scan sequencer model: issues one-cycle scans as the ladder program does.
// assumes the unit drops scans while busy, so the model holds them back.
`timescale 1ns/1ps
module wbm_scan_seq (
    input wire clk,
    input wire rst_n,
    input wire go,
    input wire [3:0] lag,
    input wire busy,
    output logic scan_pulse
);
    // ==========
    // a requested scan waits lag cycles, then for the unit to be idle
    logic pend_q;
    logic [3:0] wait_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            wait_q <= 4'h0;
            scan_pulse <= 1'b0;
        end else begin
            scan_pulse <= 1'b0;
            if (go) begin
                pend_q <= 1'b1;
                wait_q <= lag;
            end else if (pend_q && wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else if (pend_q && !busy) begin
                scan_pulse <= 1'b1;
                pend_q <= 1'b0;
            end
        end
    end
endmodule
